// >>> uart_iid_defines.vh
// Purpose: constants for the serial port interrupt identification block
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes: included by both design files
`ifndef UART_IID_DEFINES_VH
`define UART_IID_DEFINES_VH
`define ADDR_IER 12'h004
`define ADDR_IID 12'h008
`define ADDR_ISTAT 12'h010
`define ADDR_IMASK 12'h014
`define ADDR_STATE 12'h018
`define CODE_LINE 3'h3
`define CODE_RXDATA 3'h2
`define CODE_TIMEOUT 3'h6
`define CODE_TXEMPTY 3'h1
`define CODE_MODEM 3'h0
`define TRIG_0 5'h01
`define TRIG_1 5'h04
`define TRIG_2 5'h08
`define TRIG_3 5'h0E
`define CHAR_TIMES 3'h4
`define FCR_EN 0
`define FCR_CLR_RX 1
`define FCR_CLR_TX 2
`define FCR_TRIG_LO 6
`define FCR_TRIG_HI 7
`endif

// >>> uart_iid_prio.v
// Purpose: ranks pending serial port interrupt sources into a code
// Assumes: inputs already gated by their enables
// Notes: purely combinational
`timescale 1ns/1ps
`include "uart_iid_defines.vh"
module uart_iid_prio (
    // gated sources
    input wire line_i,
    input wire rxdata_i,
    input wire timeout_i,
    input wire txempty_i,
    input wire modem_i,
    // result
    output reg [2:0] code_o,
    output reg pending_o
);
    // fixed priority encode
    always @* begin
        pending_o = 1'b1;
        if (line_i) begin
            code_o = `CODE_LINE;
        end else if (rxdata_i) begin
            code_o = `CODE_RXDATA;
        end else if (timeout_i) begin
            code_o = `CODE_TIMEOUT;
        end else if (txempty_i) begin
            code_o = `CODE_TXEMPTY;
        end else if (modem_i) begin
            code_o = `CODE_MODEM;
        end else begin
            code_o = `CODE_MODEM;
            pending_o = 1'b0;
        end
    end
endmodule // uart_iid_prio

// >>> uart_interrupt_identification.v
// Purpose: interrupt identification, threshold select and timeout for a serial port
// Assumes: receiver, transmitter and status logic on the same clock
// Notes: APB slave, zero wait states except one at identification reads
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "uart_iid_defines.vh"
module uart_interrupt_identification #(
    parameter CHAR_CYCLES = 16'd1000,
    parameter FIFO_DEPTH_W = 5
) (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // serial port status from same clock
    input wire line_err_i,
    input wire [FIFO_DEPTH_W-1:0] rx_count_i,
    input wire rx_push_i,
    input wire tx_empty_i,
    input wire modem_change_i,
    // host side events from other registers
    input wire lsr_read_i,
    input wire rbr_read_i,
    input wire thr_write_i,
    input wire msr_read_i,
    // fifo control outputs
    output wire fifo_enable_bit_o,
    output wire [1:0] rx_threshold_select_o,
    output reg rx_fifo_clear_o,
    output reg tx_fifo_clear_o,
    // interrupt
    output wire irq_o
);
    reg rst_s1_r, rst_s2_r;
    wire rst_n;
    reg [3:0] ier_r;
    reg fen_r;
    reg [1:0] thr_sel_r;
    reg line_r, modem_r, txe_r, tmo_r;
    reg txe_prev_r;
    reg [15:0] char_cnt_r;
    reg [2:0] char_times_r;
    reg [2:0] held_code_r;
    reg held_pend_r;
    reg iid_wait_r;
    reg [4:0] istat_r;
    reg [4:0] imask_r;
    wire [2:0] code;
    wire pending;
    wire [4:0] trig;
    wire rx_at_trig, rx_any, rx_data_src;
    wire setup, access, wr, rd;
    wire iid_rd_done;
    wire [4:0] ev;

    // threshold decode
    function [4:0] trig_bytes;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trig_bytes = `TRIG_0;
                2'h1: trig_bytes = `TRIG_1;
                2'h2: trig_bytes = `TRIG_2;
                default: trig_bytes = `TRIG_3;
            endcase
        end
    endfunction

    // reset release
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // bus phases
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign pready_o = !(access && !pwrite_i && paddr_i == `ADDR_IID && !iid_wait_r);
    assign pslverr_o = 1'b0;
    assign wr = access && pready_o && pwrite_i;
    assign rd = access && pready_o && !pwrite_i;
    assign iid_rd_done = rd && paddr_i == `ADDR_IID;

    // receive data source
    assign trig = trig_bytes(thr_sel_r);
    assign rx_any = rx_count_i != {FIFO_DEPTH_W{1'b0}};
    assign rx_at_trig = {{(8-FIFO_DEPTH_W){1'b0}}, rx_count_i} >= {3'h0, trig};
    assign rx_data_src = fen_r ? rx_at_trig : rx_any;
    assign fifo_enable_bit_o = fen_r;
    assign rx_threshold_select_o = thr_sel_r;

    // prioritiser on enabled sources
    uart_iid_prio u_prio (
        .line_i(line_r && ier_r[2]),
        .rxdata_i(rx_data_src && ier_r[0]),
        .timeout_i(tmo_r && ier_r[0]),
        .txempty_i(txe_r && ier_r[1]),
        .modem_i(modem_r && ier_r[3]),
        .code_o(code),
        .pending_o(pending)
    );

    // registers, sticky sources and identification hold
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ier_r <= 4'h0;
            fen_r <= 1'b0;
            thr_sel_r <= 2'h0;
            line_r <= 1'b0;
            modem_r <= 1'b0;
            txe_r <= 1'b0;
            txe_prev_r <= 1'b0;
            held_code_r <= 3'h0;
            held_pend_r <= 1'b0;
            iid_wait_r <= 1'b0;
            rx_fifo_clear_o <= 1'b0;
            tx_fifo_clear_o <= 1'b0;
            imask_r <= 5'h00;
        end else begin
            txe_prev_r <= tx_empty_i;
            rx_fifo_clear_o <= 1'b0;
            tx_fifo_clear_o <= 1'b0;
            // capture at setup of an identification read
            iid_wait_r <= access && !pwrite_i && paddr_i == `ADDR_IID && !iid_wait_r;
            if (setup && !pwrite_i && paddr_i == `ADDR_IID) begin
                held_code_r <= code;
                held_pend_r <= pending;
            end
            // line status: set wins over clear
            if (line_err_i) begin
                line_r <= 1'b1;
            end else if (lsr_read_i) begin
                line_r <= 1'b0;
            end
            if (modem_change_i) begin
                modem_r <= 1'b1;
            end else if (msr_read_i) begin
                modem_r <= 1'b0;
            end
            // transmit empty set on rising empty
            if (tx_empty_i && !txe_prev_r) begin
                txe_r <= 1'b1;
            end else if (thr_write_i || (iid_rd_done && held_pend_r && held_code_r == `CODE_TXEMPTY)) begin
                txe_r <= 1'b0;
            end
            if (wr && paddr_i == `ADDR_IER) begin
                ier_r <= pwdata_i[3:0];
            end
            if (wr && paddr_i == `ADDR_IID) begin
                fen_r <= pwdata_i[`FCR_EN];
                if (pwdata_i[`FCR_EN]) begin
                    thr_sel_r <= pwdata_i[`FCR_TRIG_HI:`FCR_TRIG_LO];
                    rx_fifo_clear_o <= pwdata_i[`FCR_CLR_RX];
                    tx_fifo_clear_o <= pwdata_i[`FCR_CLR_TX];
                end else begin
                    rx_fifo_clear_o <= 1'b1;
                    tx_fifo_clear_o <= 1'b1;
                end
            end
            if (wr && paddr_i == `ADDR_IMASK) begin
                imask_r <= pwdata_i[4:0];
            end
        end
    end

    // character timeout: four idle character times with data held
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            char_cnt_r <= 16'h0000;
            char_times_r <= 3'h0;
            tmo_r <= 1'b0;
        end else if (!fen_r || !rx_any || rx_push_i || rbr_read_i) begin
            char_cnt_r <= 16'h0000;
            char_times_r <= 3'h0;
            tmo_r <= 1'b0;
        end else if (char_times_r == `CHAR_TIMES) begin
            tmo_r <= 1'b1;
        end else if (char_cnt_r == CHAR_CYCLES - 16'd1) begin
            char_cnt_r <= 16'h0000;
            char_times_r <= char_times_r + 3'h1;
        end else begin
            char_cnt_r <= char_cnt_r + 16'h0001;
        end
    end

    // interrupt status: events are the ungated source pulses, with transmit empty taken on its rising edge
    // timeout event is the cycle in which the timer sets its flag
    assign ev = {modem_change_i, tx_empty_i && !txe_prev_r,
                 !tmo_r && char_times_r == `CHAR_TIMES && fen_r && rx_any && !rx_push_i && !rbr_read_i,
                 line_err_i, rx_push_i};
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            istat_r <= 5'h00;
        end else if (wr && paddr_i == `ADDR_ISTAT) begin
            istat_r <= (istat_r & ~pwdata_i[4:0]) | ev;
        end else begin
            istat_r <= istat_r | ev;
        end
    end
    assign irq_o = |(istat_r & imask_r);

    // read data
    always @* begin
        prdata_o = 32'h0000_0000;
        case (paddr_i)
            `ADDR_IER: prdata_o = {28'h0000000, ier_r};
            `ADDR_IID: prdata_o = {24'h000000, {2{fen_r}}, 2'h0,
                                   (fen_r ? held_code_r[2] : 1'b0), held_code_r[1:0], !held_pend_r};
            `ADDR_ISTAT: prdata_o = {27'h0000000, istat_r};
            `ADDR_IMASK: prdata_o = {27'h0000000, imask_r};
            `ADDR_STATE: prdata_o = {24'h000000, line_r, modem_r, txe_r, tmo_r, thr_sel_r, fen_r, pending};
            default: prdata_o = 32'h0000_0000;
        endcase
    end
endmodule // uart_interrupt_identification

// >>> uart_iid_chk.sv
// Purpose: port assertions for the identification block
// Assumes: apb master holds each request until pready
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`include "uart_iid_defines.vh"
module uart_iid_chk (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    // fifo control
    input wire fifo_enable_bit_o,
    input wire [1:0] rx_threshold_select_o,
    input wire rx_fifo_clear_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // id read access and taken control write
    wire idr = psel_i && penable_i && !pwrite_i && paddr_i == `ADDR_IID;
    wire fcw = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `ADDR_IID;
    sequence s_idset;
        psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_IID;
    endsequence
    sequence s_wait1;
        !pready_o ##1 pready_o;
    endsequence
    chk_id_wait: assert property (s_idset |=> s_wait1)
        else $error("id read wait wrong");
    chk_id_hold: assert property (idr && !pready_o |=> $stable(prdata_o))
        else $error("id code moved in access");
    chk_zero_wait: assert property (psel_i && penable_i && !idr |-> pready_o)
        else $error("wait state on plain access");
    chk_fifo_bits: assert property (idr |-> prdata_o[7:6] == {2{fifo_enable_bit_o}})
        else $error("fifo bits wrong");
    chk_bit3_off: assert property (idr && !fifo_enable_bit_o |-> !prdata_o[3])
        else $error("bit 3 set outside fifo mode");
    chk_idle_code: assert property (idr && prdata_o[0] |-> prdata_o[3:1] == 3'h0)
        else $error("type set with none pending");
    chk_fifo_en: assert property (fcw |=> fifo_enable_bit_o == $past(pwdata_i[0]))
        else $error("fifo enable not taken");
    chk_trig_sel: assert property (fcw && pwdata_i[0] |=> rx_threshold_select_o == $past(pwdata_i[7:6]))
        else $error("threshold not taken");
    chk_rx_flush: assert property (fcw && pwdata_i[1:0] == 2'h3 |=> rx_fifo_clear_o ##1 !rx_fifo_clear_o)
        else $error("rx clear pulse wrong");
endmodule // uart_iid_chk

// >>> uart_far_rx.sv
// Purpose: receive fifo occupancy model of the serial side
// Assumes: at most one push and one pop per cycle
// Notes: emptied by the clear pulse or by fifo disable
`timescale 1ns/1ps
module uart_far_rx (
    input wire clk_i,
    input wire rst_b_i,
    input wire push_i,
    input wire pop_i,
    input wire clr_i,
    input wire en_i,
    output reg push_o,
    output reg [4:0] cnt_o
);
    reg en_q;
    // count follows pushes and buffer reads
    always @(posedge clk_i) begin
        push_o <= push_i;
        en_q <= en_i;
        if (!rst_b_i || clr_i || (en_q && !en_i)) begin
            cnt_o <= 5'h00;
        end else begin
            cnt_o <= cnt_o + {4'h0, push_i} - {4'h0, pop_i && cnt_o != 5'h00};
        end
    end
endmodule // uart_far_rx

// >>> test_uart_interrupt_identification.sv
// Purpose: self-checking bench for the identification block
// Assumes: char time of 10 clocks
// Notes: expected read values are queued and compared by a monitor
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_uart_interrupt_identification;
    logic clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, tx_empty_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, s = 32'd88972, ex;
    logic [6:0] ev = 7'h00;
    logic [31:0] q[$];
    int err_count = 0, num_checks = 0;
    int tg[4] = '{1, 4, 8, 14};
    wire [31:0] prdata_o;
    wire [4:0] rx_count_i;
    wire [1:0] rx_threshold_select_o;
    wire pready_o, pslverr_o, rx_push_i, fifo_enable_bit_o, rx_fifo_clear_o, tx_fifo_clear_o, irq_o;
    wire line_err_i = ev[0], modem_change_i = ev[1], lsr_read_i = ev[2], msr_read_i = ev[3];
    wire rbr_read_i = ev[5], thr_write_i = ev[6];
    uart_interrupt_identification #(.CHAR_CYCLES(16'd10)) u_uart_interrupt_identification (.clk_i, .rst_b_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .line_err_i,
        .rx_count_i, .rx_push_i, .tx_empty_i, .modem_change_i, .lsr_read_i, .rbr_read_i, .thr_write_i,
        .msr_read_i, .fifo_enable_bit_o, .rx_threshold_select_o, .rx_fifo_clear_o, .tx_fifo_clear_o, .irq_o);
    uart_far_rx u_uart_far_rx (.clk_i, .rst_b_i, .push_i(ev[4]), .pop_i(ev[5]), .clr_i(rx_fifo_clear_o),
        .en_i(fifo_enable_bit_o), .push_o(rx_push_i), .cnt_o(rx_count_i));
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        n = 0;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
        psel_i <= 0;
        penable_i <= 0;
        if (n == 20) begin
            err_count++;
            stop_test();
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(0, a, 32'h0);
    endtask
    task pulse(input logic [6:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 7'h00;
    endtask
    // compare each taken read with the oldest note
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && q.size() > 0) begin
            ex = q.pop_front();
            `CHK("prdata", ex, prdata_o)
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1;
        repeat (3) @(posedge clk_i);
        rd(12'h008, 32'h01);
        bus(1, 12'h014, 32'h1F);
        bus(1, 12'h004, 32'h0F);
        @(posedge clk_i) tx_empty_i <= 1;
        pulse(7'h13);
        rd(12'h008, 32'h06);
        pulse(7'h04);
        rd(12'h008, 32'h04);
        pulse(7'h20);
        rd(12'h008, 32'h02);
        rd(12'h008, 32'h00);
        pulse(7'h08);
        rd(12'h008, 32'h01);
        bus(1, 12'h014, 32'h00);
        #1 `CHK("irq", 1'b0, irq_o)
        bus(1, 12'h014, 32'h1F);
        #1 `CHK("irq", 1'b1, irq_o)
        bus(1, 12'h010, 32'h1F);
        #1 `CHK("irq", 1'b0, irq_o)
        bus(1, 12'h004, 32'h00);
        @(posedge clk_i) tx_empty_i <= 0;
        @(posedge clk_i) tx_empty_i <= 1;
        pulse(7'h03);
        rd(12'h008, 32'h01);
        pulse(7'h4C);
        bus(1, 12'h0F0, xs());
        rd(12'h0F0, 32'h00);
        bus(1, 12'h004, 32'h01);
        for (int c = 0; c < 4; c++) begin
            bus(1, 12'h008, {24'h0, c[1:0], 6'h03});
            repeat (tg[c] - 1) pulse(7'h10);
            rd(12'h008, 32'hC1);
            pulse(7'h10);
            rd(12'h008, 32'hC4);
        end
        pulse(7'h20);
        repeat (50) @(posedge clk_i);
        rd(12'h008, 32'hCC);
        rd(12'h010, 32'h1F);
        pulse(7'h20);
        rd(12'h008, 32'hC1);
        bus(1, 12'h008, 32'h00);
        rd(12'h008, 32'h01);
        stop_test();
    end
endmodule // test_uart_interrupt_identification
bind uart_interrupt_identification uart_iid_chk u_chk (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .fifo_enable_bit_o, .rx_threshold_select_o, .rx_fifo_clear_o);
